// ---- rtl/qdsc_serial_ctrl.sv ----
`timescale 1ns/10ps
module qdsc_serial_ctrl
   import qdsc_pkg::*;
#(
   parameter int CLK_MHZ = 40,
   parameter int WAKE_CYCLES = WAKE_US * CLK_MHZ
) (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic cs_n_i,
   input wire logic sclk_i,
   input wire logic sdi_i,
   output logic sdo_o,
   output logic sdo_oe_n_o,
   input wire logic load_strobe_n_i,
   input wire logic [1:0] gp_pin_i,
   output logic [1:0] gp_pin_o,
   output logic [1:0] gp_pin_oe_n_o,
   output logic [4:0] monitor_sel_o,
   output logic monitor_pin_oe_n_o,
   output logic group_a_sleep_o,
   output logic group_b_sleep_o,
   output logic group_a_ready_o,
   output logic group_b_ready_o,
   output logic [3:0] latch_load_o,
   output logic [13:0] ch_latch0_o,
   output logic [13:0] ch_latch1_o,
   output logic [13:0] ch_latch2_o,
   output logic [13:0] ch_latch3_o
);
   logic rs1_q;
   logic rst_q;
   logic [3:0] pins;
   logic sdi_s;
   logic cs_n_s;
   logic sclk_s;
   logic ldn_s;
   logic [1:0] gp_s;
   logic sclk_prev_q;
   logic cs_prev_q;
   qdsc_link_type link_q;
   logic [23:0] shift_q;
   logic [5:0] edge_cnt_q;
   logic [15:0] out_q;
   logic sdo_q;
   logic [3:0] rd_addr_q;
   logic [15:0] command_q;
   logic [15:0] monitor_q;
   logic [15:0] ch_in_q [4];
   logic [13:0] ch_lat_q [4];
   logic [15:0] zero_q [4];
   logic [15:0] gain_q [4];
   logic [3:0] touched_q;
   logic ldn_prev_q;
   logic soft_rst_q;
   logic [$clog2(WAKE_CYCLES+1)-1:0] wake_a_q;
   logic [$clog2(WAKE_CYCLES+1)-1:0] wake_b_q;
   logic fall;
   logic rise;
   logic frame_end;
   logic frame_ok;
   logic wr_en;
   logic [3:0] addr;
   logic [15:0] wdata;
   logic load_now;

   function automatic logic [15:0] read_reg(input logic [3:0] a);
      logic [15:0] v;
      v = 16'h0000;
      if (a == ADDR_COMMAND) begin
         v = command_q;
         v[CMD_GP1] = gp_s[1] & command_q[CMD_GP1];
         v[CMD_GP0] = gp_s[0] & command_q[CMD_GP0];
      end else if (a == ADDR_MONITOR) begin
         v = monitor_q;
      end else if (a[3:2] == ADDR_CH0[3:2]) begin
         v = ch_in_q[a[1:0]];
      end else if (a[3:2] == ADDR_ZERO0[3:2]) begin
         v = zero_q[a[1:0]];
      end else if (a[3:2] == ADDR_GAIN0[3:2]) begin
         v = gain_q[a[1:0]];
      end
      return v;
   endfunction : read_reg

   // ==========================================================
   // Reset release and pin synchronisers
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rs1_q <= 1'b0;
         rst_q <= 1'b0;
      end else begin
         rs1_q <= 1'b1;
         rst_q <= rs1_q;
      end
   end

   qdsc_pin_sync #(
      .WIDTH(4)
   ) u_link_sync (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rst_q),
      .ce_i(ce_i),
      .pin_i({cs_n_i, sclk_i, load_strobe_n_i, sdi_i}),
      .init_i(4'b1010),
      .level_o(pins)
   );

   qdsc_pin_sync #(
      .WIDTH(2)
   ) u_gp_sync (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rst_q),
      .ce_i(ce_i),
      .pin_i(gp_pin_i),
      .init_i(2'b11),
      .level_o(gp_s)
   );

   assign cs_n_s = pins[3];
   assign sclk_s = pins[2];
   assign ldn_s = pins[1];
   assign sdi_s = pins[0];

   // ==========================================================
   // Link edge detection and frame state
   assign fall = sclk_prev_q & ~sclk_s & ~cs_n_s & (link_q == LINK_SHIFT);
   assign rise = ~sclk_prev_q & sclk_s & ~cs_n_s & (link_q == LINK_SHIFT);
   assign frame_end = (link_q == LINK_SHIFT) & cs_n_s;
   assign frame_ok = frame_end & (edge_cnt_q >= 6'(FRAME_BITS));
   assign addr = shift_q[ADDR_HI:ADDR_LO];
   assign wdata = shift_q[DATA_HI:0];
   assign wr_en = frame_ok & ~shift_q[RW_POS];

   always_ff @(posedge clk_sys_i or negedge rst_q) begin
      if (!rst_q) begin
         sclk_prev_q <= 1'b0;
         cs_prev_q <= 1'b1;
         link_q <= LINK_IDLE;
      end else if (ce_i) begin
         sclk_prev_q <= sclk_s;
         cs_prev_q <= cs_n_s;
         case (link_q)
            LINK_IDLE: begin
               if (cs_prev_q & ~cs_n_s & ~soft_rst_q) begin
                  link_q <= LINK_SHIFT;
               end
            end
            LINK_SHIFT: begin
               if (cs_n_s) begin
                  link_q <= LINK_END;
               end
            end
            default: begin
               link_q <= LINK_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Shift register, edge counter and output path
   always_ff @(posedge clk_sys_i or negedge rst_q) begin
      if (!rst_q) begin
         shift_q <= SHIFT_RESET;
         edge_cnt_q <= 6'h00;
         out_q <= 16'h0000;
         sdo_q <= 1'b0;
      end else if (ce_i) begin
         if (link_q == LINK_IDLE && cs_prev_q && !cs_n_s) begin
            edge_cnt_q <= 6'h00;
            out_q <= read_reg(rd_addr_q);
            sdo_q <= 1'b0;
         end else if (fall) begin
            shift_q <= {shift_q[22:0], sdi_s};
            if (edge_cnt_q < 6'(FRAME_BITS)) begin
               edge_cnt_q <= edge_cnt_q + 6'h01;
            end
         end else if (rise) begin
            if (edge_cnt_q >= 6'd8 && edge_cnt_q < 6'(FRAME_BITS)) begin
               sdo_q <= out_q[15];
               out_q <= {out_q[14:0], 1'b0};
            end else if (edge_cnt_q >= 6'(FRAME_BITS)) begin
               sdo_q <= shift_q[23];
            end else begin
               sdo_q <= 1'b0;
            end
         end
      end
   end

   assign sdo_o = sdo_q;
   assign sdo_oe_n_o = cs_n_s | command_q[CMD_SO_DIS] | (link_q != LINK_SHIFT);

   // ==========================================================
   // Register file
   always_ff @(posedge clk_sys_i or negedge rst_q) begin
      if (!rst_q) begin
         command_q <= CMD_RESET;
         monitor_q <= 16'h0000;
         rd_addr_q <= 4'h0;
         soft_rst_q <= 1'b0;
         for (int i = 0; i < 4; i++) begin
            ch_in_q[i] <= 16'h0000;
            zero_q[i] <= 16'h0000;
            gain_q[i] <= 16'h0000;
         end
      end else if (ce_i) begin
         command_q[CMD_LATCH_LOAD] <= 1'b0;
         soft_rst_q <= 1'b0;
         if (soft_rst_q) begin
            command_q <= CMD_RESET;
            monitor_q <= 16'h0000;
            rd_addr_q <= 4'h0;
            for (int i = 0; i < 4; i++) begin
               ch_in_q[i] <= 16'h0000;
               zero_q[i] <= 16'h0000;
               gain_q[i] <= 16'h0000;
            end
         end else if (frame_ok && shift_q[RW_POS]) begin
            rd_addr_q <= addr;
         end else if (wr_en) begin
            if (addr == ADDR_COMMAND) begin
               command_q <= wdata & CMD_WMASK & ~(16'h0001 << CMD_SOFT_RESET);
               soft_rst_q <= wdata[CMD_SOFT_RESET];
            end else if (addr == ADDR_MONITOR) begin
               monitor_q <= wdata & MON_WMASK;
            end else if (addr[3:2] == ADDR_CH0[3:2]) begin
               ch_in_q[addr[1:0]] <= wdata & CH_WMASK;
            end else if (addr[3:2] == ADDR_ZERO0[3:2]) begin
               zero_q[addr[1:0]] <= wdata & ZERO_WMASK;
            end else if (addr[3:2] == ADDR_GAIN0[3:2]) begin
               gain_q[addr[1:0]] <= wdata & GAIN_WMASK;
            end
         end
      end
   end

   // ==========================================================
   // Latch update
   assign load_now = (ldn_prev_q & ~ldn_s) | command_q[CMD_LATCH_LOAD];

   always_ff @(posedge clk_sys_i or negedge rst_q) begin
      if (!rst_q) begin
         ldn_prev_q <= 1'b1;
         touched_q <= 4'h0;
         latch_load_o <= 4'h0;
         for (int i = 0; i < 4; i++) begin
            ch_lat_q[i] <= 14'h0000;
         end
      end else if (ce_i) begin
         ldn_prev_q <= ldn_s;
         latch_load_o <= 4'h0;
         if (soft_rst_q) begin
            touched_q <= 4'h0;
            for (int i = 0; i < 4; i++) begin
               ch_lat_q[i] <= 14'h0000;
            end
         end else begin
            for (int i = 0; i < 4; i++) begin
               if (wr_en && addr == (ADDR_CH0 | 4'(i))) begin
                  if (!ldn_s) begin
                     ch_lat_q[i] <= wdata[DATA_HI:DATA_LO];
                     latch_load_o[i] <= 1'b1;
                     touched_q[i] <= 1'b0;
                  end else begin
                     touched_q[i] <= 1'b1;
                  end
               end else if (load_now && touched_q[i]) begin
                  ch_lat_q[i] <= ch_in_q[i][DATA_HI:DATA_LO];
                  latch_load_o[i] <= 1'b1;
                  touched_q[i] <= 1'b0;
               end
            end
         end
      end
   end

   assign ch_latch0_o = ch_lat_q[0];
   assign ch_latch1_o = ch_lat_q[1];
   assign ch_latch2_o = ch_lat_q[2];
   assign ch_latch3_o = ch_lat_q[3];

   // ==========================================================
   // Group sleep and wake timing
   always_ff @(posedge clk_sys_i or negedge rst_q) begin
      if (!rst_q) begin
         wake_a_q <= '0;
         wake_b_q <= '0;
      end else if (ce_i) begin
         if (command_q[CMD_SLEEP_A]) begin
            wake_a_q <= ($bits(wake_a_q))'(WAKE_CYCLES);
         end else if (wake_a_q != '0) begin
            wake_a_q <= wake_a_q - 1'b1;
         end
         if (command_q[CMD_SLEEP_B]) begin
            wake_b_q <= ($bits(wake_b_q))'(WAKE_CYCLES);
         end else if (wake_b_q != '0) begin
            wake_b_q <= wake_b_q - 1'b1;
         end
      end
   end

   assign group_a_sleep_o = command_q[CMD_SLEEP_A];
   assign group_b_sleep_o = command_q[CMD_SLEEP_B];
   assign group_a_ready_o = (wake_a_q == '0) & ~command_q[CMD_SLEEP_A];
   assign group_b_ready_o = (wake_b_q == '0) & ~command_q[CMD_SLEEP_B];

   // ==========================================================
   // General pins and monitor selection
   assign gp_pin_o = 2'b00;
   assign gp_pin_oe_n_o = {command_q[CMD_GP1], command_q[CMD_GP0]};

   always_comb begin
      monitor_sel_o = 5'h00;
      if (monitor_q[MON_CH_LO+3]) begin
         monitor_sel_o = 5'h08;
      end else if (monitor_q[MON_CH_LO+2]) begin
         monitor_sel_o = 5'h04;
      end else if (monitor_q[MON_CH_LO+1]) begin
         monitor_sel_o = 5'h02;
      end else if (monitor_q[MON_CH_LO]) begin
         monitor_sel_o = 5'h01;
      end else if (monitor_q[MON_AUX]) begin
         monitor_sel_o = 5'h10;
      end
   end

   assign monitor_pin_oe_n_o = (monitor_sel_o == 5'h00);

endmodule : qdsc_serial_ctrl

// ---- rtl/qdsc_pkg.sv ----
package qdsc_pkg;

   // ==========================================================
   // Frame layout
   localparam int FRAME_BITS = 24;
   localparam int RW_POS = 23;
   localparam int ADDR_HI = 19;
   localparam int ADDR_LO = 16;
   localparam int DATA_HI = 15;
   localparam int DATA_LO = 2;
   localparam logic [23:0] SHIFT_RESET = 24'h000000;

   // ==========================================================
   // Register addresses
   localparam logic [3:0] ADDR_COMMAND = 4'h0;
   localparam logic [3:0] ADDR_MONITOR = 4'h1;
   localparam logic [3:0] ADDR_CH0 = 4'h4;
   localparam logic [3:0] ADDR_ZERO0 = 4'h8;
   localparam logic [3:0] ADDR_GAIN0 = 4'hc;

   // ==========================================================
   // Command register fields and reset value
   localparam int CMD_GROUP_SEL = 15;
   localparam int CMD_LATCH_LOAD = 14;
   localparam int CMD_SOFT_RESET = 13;
   localparam int CMD_SLEEP_A = 12;
   localparam int CMD_SLEEP_B = 11;
   localparam int CMD_GP1 = 9;
   localparam int CMD_GP0 = 8;
   localparam int CMD_SO_DIS = 7;
   localparam logic [15:0] CMD_RESET = 16'h033c;
   localparam logic [15:0] CMD_WMASK = 16'hfbfc;

   // ==========================================================
   // Monitor register fields and register write masks
   localparam int MON_CH_LO = 12;
   localparam int MON_AUX = 11;
   localparam logic [15:0] MON_WMASK = 16'hf800;
   localparam logic [15:0] CH_WMASK = 16'hfffc;
   localparam logic [15:0] ZERO_WMASK = 16'h01ff;
   localparam logic [15:0] GAIN_WMASK = 16'h00ff;

   // ==========================================================
   // Timing
   localparam int WAKE_US = 50;

   typedef enum logic [1:0] {
      LINK_IDLE,
      LINK_SHIFT,
      LINK_END
   } qdsc_link_type;

endpackage : qdsc_pkg

// ---- rtl/qdsc_pin_sync.sv ----
`timescale 1ns/10ps
module qdsc_pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic [WIDTH-1:0] pin_i,
   input wire logic [WIDTH-1:0] init_i,
   output logic [WIDTH-1:0] level_o
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] lvl_q;
   logic [WIDTH-1:0] init_q;

   // ==========================================================
   // Three stages; a change counts once stages two and three agree.
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s1_q <= '1;
         s2_q <= '1;
         s3_q <= '1;
         lvl_q <= '1;
         init_q <= '0;
      end else if (ce_i) begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         init_q <= {WIDTH{1'b1}};
         for (int i = 0; i < WIDTH; i++) begin
            if (!init_q[i]) begin
               lvl_q[i] <= init_i[i];
            end else if (s2_q[i] == s3_q[i]) begin
               lvl_q[i] <= s3_q[i];
            end
         end
      end
   end

   assign level_o = lvl_q;

endmodule : qdsc_pin_sync

// ---- sim/qdsc_serial_ctrl_asserts.sv ----
`timescale 1ns/10ps
module qdsc_serial_ctrl_asserts #(
   parameter int WAKE_CYCLES = 2000
) (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic cs_n_i,
   input wire logic sdo_oe_n_o,
   input wire logic [1:0] gp_pin_o,
   input wire logic [4:0] monitor_sel_o,
   input wire logic monitor_pin_oe_n_o,
   input wire logic group_a_sleep_o,
   input wire logic group_b_sleep_o,
   input wire logic group_a_ready_o,
   input wire logic group_b_ready_o,
   input wire logic [3:0] latch_load_o,
   input wire logic [13:0] ch_latch0_o
);
   // ==========
   // Wake counter.
   logic [15:0] wake_q;
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wake_q <= 16'h0000;
      end else if (!group_a_sleep_o && !group_a_ready_o) begin
         wake_q <= wake_q + 16'h0001;
      end else begin
         wake_q <= 16'h0000;
      end
   end
   // ==========
   // Checks.
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   AST_GP_LOW: assert property (gp_pin_o == 2'b00)
      else $error("general pin driven high");
   AST_MON_FLOAT: assert property (monitor_pin_oe_n_o == (monitor_sel_o == 5'h00))
      else $error("monitor enable wrong");
   AST_MON_ONE: assert property ($onehot0(monitor_sel_o))
      else $error("monitor routes several");
   AST_CS_FLOAT: assert property (cs_n_i [*6] |-> sdo_oe_n_o)
      else $error("serial out driven while idle");
   AST_SLEEP_A: assert property (group_a_sleep_o |-> !group_a_ready_o)
      else $error("group a ready while asleep");
   AST_SLEEP_B: assert property (group_b_sleep_o |-> !group_b_ready_o)
      else $error("group b ready while asleep");
   AST_WAKE: assert property (int'(wake_q) <= WAKE_CYCLES + 2)
      else $error("wake too slow");
   AST_LATCH_CHG: assert property ($changed(ch_latch0_o) && ch_latch0_o != 14'h0000 |->
      latch_load_o[0] || $past(latch_load_o[0])) else $error("latch changed without load");
   AST_PULSE: assert property (latch_load_o[0] |=> !latch_load_o[0])
      else $error("load pulse too long");
endmodule : qdsc_serial_ctrl_asserts
bind qdsc_serial_ctrl qdsc_serial_ctrl_asserts #(.WAKE_CYCLES(WAKE_CYCLES)) i_asserts (
   .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i), .sdo_oe_n_o(sdo_oe_n_o),
   .gp_pin_o(gp_pin_o), .monitor_sel_o(monitor_sel_o), .monitor_pin_oe_n_o(monitor_pin_oe_n_o),
   .group_a_sleep_o(group_a_sleep_o), .group_b_sleep_o(group_b_sleep_o),
   .group_a_ready_o(group_a_ready_o), .group_b_ready_o(group_b_ready_o),
   .latch_load_o(latch_load_o), .ch_latch0_o(ch_latch0_o)
);

// ---- sim/qdsc_host_model.sv ----
`timescale 1ns/10ps
module qdsc_host_model (
   input wire logic clk_i,
   input wire logic sdo_i,
   output logic cs_n_o,
   output logic sclk_o,
   output logic sdi_o
);
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      sdi_o = 1'b0;
   end
   // ==========
   // One framed transfer.
   task automatic frame(input logic [31:0] w, input int n, output logic [31:0] rx);
      rx = 32'h0000_0000;
      @(posedge clk_i);
      cs_n_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      for (int i = n - 1; i >= 0; i--) begin
         sclk_o <= 1'b1;
         repeat (2) @(posedge clk_i);
         sdi_o <= w[i];
         repeat (2) @(posedge clk_i);
         sclk_o <= 1'b0;
         repeat (3) @(posedge clk_i);
         @(negedge clk_i);
         rx = {rx[30:0], sdo_i};
         @(posedge clk_i);
      end
      repeat (2) @(posedge clk_i);
      cs_n_o <= 1'b1;
      sdi_o <= ~sdi_o;
   endtask : frame
endmodule : qdsc_host_model

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
module testbench;
   import qdsc_pkg::*;
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %0t got %h", $time, g); end end
   logic clk_sys_i, rstn_i, cs_n, sclk, sdi, sdo, sdo_oe_n, load_n, mon_oe_n, lo_seen;
   logic a_sleep, b_sleep, a_rdy, b_rdy;
   logic [1:0] gp_ext, gp_oe_n;
   logic [3:0] ld;
   logic [4:0] mon_sel;
   logic [13:0] l0, l1, l2;
   logic [31:0] rx;
   logic [15:0] mv [3] = '{16'h1000, 16'h0800, 16'h0000};
   logic [5:0] ms [3] = '{6'h01, 6'h10, 6'h20};
   int n_errors = 0;
   int checks = 0;
   initial begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) if (!sdo_oe_n) lo_seen <= 1'b1;
   qdsc_serial_ctrl #(.WAKE_CYCLES(20)) i_dut (
      .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(1'b1), .cs_n_i(cs_n), .sclk_i(sclk),
      .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n), .load_strobe_n_i(load_n),
      .gp_pin_i(gp_oe_n & gp_ext), .gp_pin_o(), .gp_pin_oe_n_o(gp_oe_n), .monitor_sel_o(mon_sel),
      .monitor_pin_oe_n_o(mon_oe_n), .group_a_sleep_o(a_sleep), .group_b_sleep_o(b_sleep),
      .group_a_ready_o(a_rdy), .group_b_ready_o(b_rdy), .latch_load_o(ld), .ch_latch0_o(l0),
      .ch_latch1_o(l1), .ch_latch2_o(l2), .ch_latch3_o()
   );
   qdsc_host_model i_host (.clk_i(clk_sys_i), .sdo_i(sdo), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi));
   function automatic logic [31:0] fw(input logic rw, input logic [3:0] a, input logic [15:0] d);
      return {8'h00, rw, 3'b000, a, d};
   endfunction : fw
   task automatic xf(input logic [31:0] w, input int n, input bit chk, input logic [15:0] exp);
      i_host.frame(w, n, rx);
      repeat (12) @(posedge clk_sys_i);
      if (chk) `CHK(rx[15:0], exp)
   endtask : xf
   task automatic results;
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : results
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      n_errors++;
      results();
   end
   // ==========
   // Main sequence.
   initial begin
      rstn_i = 1'b0;
      load_n = 1'b1;
      gp_ext = 2'b11;
      lo_seen = 1'b0;
      repeat (20) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      repeat (10) @(posedge clk_sys_i);
      `CHK({gp_oe_n, sdo_oe_n, mon_oe_n}, 4'hf)
      xf(fw(1'b0, ADDR_CH0, 16'h1234), 24, 0, 16'h0000);
      `CHK(l0, 14'h0000)
      xf(fw(1'b1, ADDR_CH0, 16'h0000), 24, 0, 16'h0000);
      xf(fw(1'b1, ADDR_CH0 + 4'h1, 16'hffff), 24, 1, 16'h1234);
      xf(fw(1'b0, 4'h2, 16'h0000), 24, 1, 16'h0000);
      load_n <= 1'b0;
      repeat (8) @(posedge clk_sys_i);
      `CHK(l0, 14'h048d)
      xf(fw(1'b0, ADDR_CH0 + 4'h1, 16'hfffc), 24, 0, 16'h0000);
      `CHK(l1, 14'h3fff)
      load_n <= 1'b1;
      xf(fw(1'b0, ADDR_CH0 + 4'h2, 16'h5554), 23, 0, 16'h0000);
      xf(fw(1'b1, ADDR_CH0 + 4'h2, 16'h0000), 24, 0, 16'h0000);
      xf(fw(1'b0, 4'h2, 16'h0000), 24, 1, 16'h0000);
      xf(fw(1'b0, ADDR_CH0 + 4'h2, 16'h5554) | 32'h0300_0000, 26, 0, 16'h0000);
      xf(fw(1'b0, ADDR_COMMAND, 16'h433c), 24, 0, 16'h0000);
      `CHK(l2, 14'h1555)
      for (int i = 0; i < 3; i++) begin
         xf(fw(1'b0, ADDR_MONITOR, mv[i]), 24, 0, 16'h0000);
         `CHK({mon_oe_n, mon_sel}, ms[i])
      end
      xf(fw(1'b0, ADDR_COMMAND, 16'h183c), 24, 0, 16'h0000);
      `CHK({a_sleep, a_rdy, b_sleep, b_rdy, gp_oe_n}, 6'b101000)
      xf(fw(1'b1, ADDR_COMMAND, 16'h0000), 24, 0, 16'h0000);
      xf(fw(1'b1, ADDR_CH0, 16'h0000), 24, 1, 16'h183c);
      xf(fw(1'b0, 4'h2, 16'h0000), 24, 1, 16'h1234);
      gp_ext <= 2'b01;
      xf(fw(1'b0, ADDR_COMMAND, 16'h033c), 24, 0, 16'h0000);
      `CHK({a_sleep, a_rdy, gp_oe_n}, 4'b0011)
      repeat (20) @(posedge clk_sys_i);
      `CHK({a_rdy, b_rdy}, 2'b11)
      xf(fw(1'b1, ADDR_COMMAND, 16'h0000), 24, 0, 16'h0000);
      xf(fw(1'b0, 4'h2, 16'h0000), 24, 1, 16'h013c);
      gp_ext <= 2'b11;
      xf(fw(1'b0, ADDR_COMMAND, 16'h03bc), 24, 0, 16'h0000);
      lo_seen <= 1'b0;
      xf(fw(1'b0, ADDR_COMMAND, 16'h033c), 24, 0, 16'h0000);
      `CHK(lo_seen, 1'b0)
      lo_seen <= 1'b0;
      xf(fw(1'b0, 4'h2, 16'h0000) | 32'ha500_0000, 32, 0, 16'h0000);
      `CHK({lo_seen, rx[7:0]}, 9'h1a5)
      xf(fw(1'b0, ADDR_COMMAND, 16'h203c), 24, 0, 16'h0000);
      `CHK(gp_oe_n, 2'b11)
      results();
   end
endmodule : testbench
